// [csrc_pkg.sv]
// Purpose: Shared constants and types for the clock source routing configuration block
// Assumes: Byte-wide registers on a 10-bit internal address bus
// Notes: Contract list below
// Contract
// - PLL power field resets to 01b, PLL powered down
// - Writing 00b to PLL power field turns PLL on
// - Oscillator divider field resets to 010b, divide by four
// - Routing bit 0 low feeds distribution through the divider
// - Routing bit 1 low selects external clock input as source
// - Staged values take effect only after host writes a value with bit 0 high to update
// - PLL control bit 7 sets phase-detector polarity, 1 negative
// - Default path: external input through divider, ratios 2 to 6
// - Divider path never divides by less than two
// - PLL on with external input powers oscillator off
// - Active-low chip reset restores every register default
`default_nettype none
package csrc_pkg;
  localparam logic [9:0] CSRC_ADDR_PLL = 10'h010;
  localparam logic [9:0] CSRC_ADDR_CAL = 10'h018;
  localparam logic [9:0] CSRC_ADDR_DIV = 10'h1e0;
  localparam logic [9:0] CSRC_ADDR_ROUTE = 10'h1e1;
  localparam logic [9:0] CSRC_ADDR_UPDATE = 10'h232;
  localparam logic [7:0] CSRC_RST_PLL = 8'h01;
  localparam logic [7:0] CSRC_RST_CAL = 8'h00;
  localparam logic [7:0] CSRC_RST_DIV = 8'h02;
  localparam logic [7:0] CSRC_RST_ROUTE = 8'h00;
  localparam logic [1:0] CSRC_PWR_ON = 2'h0;
  localparam int CSRC_POL_BIT = 7;
  localparam int CSRC_BYP_BIT = 0;
  localparam int CSRC_SRC_BIT = 1;
  localparam int CSRC_CAL_BIT = 0;
  localparam int CSRC_UPD_BIT = 0;
  localparam logic [2:0] CSRC_DIV_MIN = 3'h0;
  localparam logic [2:0] CSRC_DIV_MAX = 3'h4;
  localparam logic [2:0] CSRC_RATIO_OFS = 3'h2;
  typedef struct packed {
    logic [7:0] pll;
    logic [7:0] cal;
    logic [7:0] div;
    logic [7:0] route;
  } csrc_cfg_t;
  localparam csrc_cfg_t CSRC_CFG_RST = '{pll: CSRC_RST_PLL, cal: CSRC_RST_CAL,
                                         div: CSRC_RST_DIV, route: CSRC_RST_ROUTE};
  typedef struct packed {
    logic pll_on;
    logic osc_on;
    logic use_osc;
    logic bypass_div;
    logic pol_negative;
    logic cal_start;
    logic [2:0] div_ratio;
  } csrc_ctl_t;
endpackage
`default_nettype wire

// [csrc_route.sv]
// Purpose: Decodes active configuration into routing and power controls
// Assumes: Input comes from active registers on the same clock
// Notes: Outputs are registered
`timescale 1ns/1ps
`default_nettype none
module csrc_route (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire csrc_pkg::csrc_cfg_t cfg,
  output csrc_pkg::csrc_ctl_t ctl
);
  csrc_pkg::csrc_ctl_t ctl_d;
  logic [2:0] sel;

  always_comb begin
    sel = cfg.div[2:0];
    // Codes past the last ratio clamp, so the path never exceeds divide by six
    if (sel > csrc_pkg::CSRC_DIV_MAX) begin
      sel = csrc_pkg::CSRC_DIV_MAX;
    end
    ctl_d.pll_on = (cfg.pll[1:0] == csrc_pkg::CSRC_PWR_ON);
    ctl_d.use_osc = cfg.route[csrc_pkg::CSRC_SRC_BIT];
    ctl_d.bypass_div = cfg.route[csrc_pkg::CSRC_BYP_BIT];
    // Oscillator stays dark unless it is the selected source
    ctl_d.osc_on = ctl_d.use_osc;
    ctl_d.pol_negative = cfg.pll[csrc_pkg::CSRC_POL_BIT];
    ctl_d.cal_start = cfg.cal[csrc_pkg::CSRC_CAL_BIT];
    ctl_d.div_ratio = sel + csrc_pkg::CSRC_RATIO_OFS;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctl <= '0;
      ctl.div_ratio <= 3'h4;
    end else begin
      ctl <= ctl_d;
    end
  end

  AST_MIN_DIV: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ctl.div_ratio >= 3'h2 && ctl.div_ratio <= 3'h6)
    else $error("divider ratio out of range");
  AST_OSC_OFF: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ctl.pll_on && !ctl.use_osc) |-> !ctl.osc_on)
    else $error("oscillator on with external source");
  AST_POL: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ##1 ctl.pol_negative == $past(cfg.pll[csrc_pkg::CSRC_POL_BIT]))
    else $error("polarity does not follow active register");
endmodule
`default_nettype wire

// [csrc_top.sv]
// Purpose: Staged and active configuration registers with update transfer
// Assumes: Serial port logic hands over byte writes and reads on clk_sys
// Notes: Reads return staged values; update reads as zero after self-clear
`timescale 1ns/1ps
`default_nettype none
module csrc_top (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [9:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output csrc_pkg::csrc_cfg_t active_cfg,
  output csrc_pkg::csrc_ctl_t clk_ctl
);
  csrc_pkg::csrc_cfg_t stage_q;
  csrc_pkg::csrc_cfg_t active_q;
  logic update_q;
  logic upd_wr;

  ////////////////////////////////////////////////////////////////////////
  assign upd_wr = reg_wr && reg_addr == csrc_pkg::CSRC_ADDR_UPDATE
                  && reg_wdata[csrc_pkg::CSRC_UPD_BIT];

  // Staging registers; the device path sees none of this until update
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stage_q <= csrc_pkg::CSRC_CFG_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        csrc_pkg::CSRC_ADDR_PLL: stage_q.pll <= reg_wdata;
        csrc_pkg::CSRC_ADDR_CAL: stage_q.cal <= reg_wdata;
        csrc_pkg::CSRC_ADDR_DIV: stage_q.div <= reg_wdata;
        csrc_pkg::CSRC_ADDR_ROUTE: stage_q.route <= reg_wdata;
        default: stage_q <= stage_q;
      endcase
    end
  end

  // Update bit lives one cycle, then clears itself
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      update_q <= 1'b0;
    end else begin
      update_q <= upd_wr;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      active_q <= csrc_pkg::CSRC_CFG_RST;
    end else if (update_q) begin
      active_q <= stage_q;
    end
  end
  assign active_cfg = active_q;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          csrc_pkg::CSRC_ADDR_PLL: reg_rdata <= stage_q.pll;
          csrc_pkg::CSRC_ADDR_CAL: reg_rdata <= stage_q.cal;
          csrc_pkg::CSRC_ADDR_DIV: reg_rdata <= stage_q.div;
          csrc_pkg::CSRC_ADDR_ROUTE: reg_rdata <= stage_q.route;
          csrc_pkg::CSRC_ADDR_UPDATE: reg_rdata <= {7'h00, update_q};
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  csrc_route u_route (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .cfg(active_q),
    .ctl(clk_ctl)
  );

  ////////////////////////////////////////////////////////////////////////
  // First edge after each reset release; defaults are checked there because
  // the disable condition hides the reset cycles themselves
  logic seen_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      seen_q <= 1'b0;
    end else begin
      seen_q <= 1'b1;
    end
  end

  sequence s_update_write;
    reg_wr && reg_addr == csrc_pkg::CSRC_ADDR_UPDATE && reg_wdata[0];
  endsequence
  sequence s_transfer;
    ##2 active_q == $past(stage_q, 1);
  endsequence
  sequence s_power_on_applied;
    ##2 clk_ctl.pll_on;
  endsequence
  sequence s_read_pll;
    reg_rd && reg_addr == csrc_pkg::CSRC_ADDR_PLL;
  endsequence
  sequence s_read_answer;
    ##1 reg_rvalid && reg_rdata == $past(stage_q.pll);
  endsequence

  AST_UPDATE_XFER: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_update_write |-> s_transfer)
    else $error("staged values not applied after update");

  AST_NO_XFER: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !update_q |=> $stable(active_q))
    else $error("active changed without update");

  AST_UPD_IGNORED: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (reg_wr && reg_addr == csrc_pkg::CSRC_ADDR_UPDATE
     && !reg_wdata[csrc_pkg::CSRC_UPD_BIT]) |=> !update_q)
    else $error("update taken with bit 0 low");

  AST_UPD_SET: assert property (@(posedge clk_sys) disable iff (!rst_n)
    upd_wr |=> update_q)
    else $error("update bit not set by write");

  AST_SELF_CLEAR: assert property (@(posedge clk_sys) disable iff (!rst_n)
    update_q && !upd_wr |=> !update_q)
    else $error("update bit did not clear");

  // Staging only moves on a write, never on an update
  AST_STAGE_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !reg_wr |=> $stable(stage_q))
    else $error("staging changed without a write");

  AST_STAGE_PLL: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (reg_wr && reg_addr == csrc_pkg::CSRC_ADDR_PLL) |=> stage_q.pll == $past(reg_wdata))
    else $error("PLL staging write lost");

  AST_STAGE_DIV: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (reg_wr && reg_addr == csrc_pkg::CSRC_ADDR_DIV) |=> stage_q.div == $past(reg_wdata))
    else $error("divider staging write lost");

  AST_STAGE_ROUTE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (reg_wr && reg_addr == csrc_pkg::CSRC_ADDR_ROUTE)
    |=> stage_q.route == $past(reg_wdata))
    else $error("routing staging write lost");

  // Reads show staged values so software can verify before committing
  AST_READ_STAGE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_read_pll |-> s_read_answer)
    else $error("read does not return staged value");

  AST_RVALID: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reg_rd |=> reg_rvalid)
    else $error("read not answered");

  AST_RVALID_LOW: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !reg_rd |=> !reg_rvalid)
    else $error("read answer without request");

  AST_RST_CFG: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !seen_q |-> active_q == csrc_pkg::CSRC_CFG_RST && stage_q == csrc_pkg::CSRC_CFG_RST)
    else $error("registers not at defaults after reset");

  AST_RST_CTL: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !seen_q |-> !clk_ctl.pll_on
    && clk_ctl.div_ratio == csrc_pkg::CSRC_RST_DIV[2:0] + csrc_pkg::CSRC_RATIO_OFS)
    else $error("decoded controls not at defaults after reset");

  AST_PWR_ON: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (update_q && stage_q.pll[1:0] == csrc_pkg::CSRC_PWR_ON) |-> s_power_on_applied)
    else $error("PLL not on after 00b applied");

  AST_PWR_OFF: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (active_q.pll[1:0] == csrc_pkg::CSRC_RST_PLL[1:0]) |=> !clk_ctl.pll_on)
    else $error("PLL on with power-down code");

  AST_PWR_OTHER: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (active_q.pll[1:0] != csrc_pkg::CSRC_PWR_ON) |=> !clk_ctl.pll_on)
    else $error("PLL on without the on code");

  AST_OSC_OFF_EXT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (active_q.pll[1:0] == csrc_pkg::CSRC_PWR_ON
     && !active_q.route[csrc_pkg::CSRC_SRC_BIT]) |=> !clk_ctl.osc_on)
    else $error("oscillator powered with PLL on external input");

  AST_SRC_SEL: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !active_q.route[1] |=> !clk_ctl.use_osc)
    else $error("oscillator selected with bit 1 low");

  AST_SRC_OSC: assert property (@(posedge clk_sys) disable iff (!rst_n)
    active_q.route[csrc_pkg::CSRC_SRC_BIT] |=> clk_ctl.use_osc && clk_ctl.osc_on)
    else $error("oscillator not selected with bit 1 high");

  AST_BYPASS: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !active_q.route[0] |=> !clk_ctl.bypass_div)
    else $error("divider bypassed with bit 0 low");

  AST_BYPASS_ON: assert property (@(posedge clk_sys) disable iff (!rst_n)
    active_q.route[csrc_pkg::CSRC_BYP_BIT] |=> clk_ctl.bypass_div)
    else $error("divider kept with bit 0 high");

  AST_DIV4: assert property (@(posedge clk_sys) disable iff (!rst_n)
    active_q.div[2:0] == 3'h2 |=> clk_ctl.div_ratio == 3'h4)
    else $error("code 010b is not divide by four");

  AST_DIV_RATIO: assert property (@(posedge clk_sys) disable iff (!rst_n)
    active_q.div[2:0] <= csrc_pkg::CSRC_DIV_MAX
    |=> clk_ctl.div_ratio == $past(active_q.div[2:0]) + csrc_pkg::CSRC_RATIO_OFS)
    else $error("divider code gives wrong ratio");

  // Codes past the table stay at the top ratio rather than wrap below two
  AST_DIV_CLAMP: assert property (@(posedge clk_sys) disable iff (!rst_n)
    active_q.div[2:0] > csrc_pkg::CSRC_DIV_MAX
    |=> clk_ctl.div_ratio == csrc_pkg::CSRC_DIV_MAX + csrc_pkg::CSRC_RATIO_OFS)
    else $error("unused divider code not clamped");

  AST_POL_NEG: assert property (@(posedge clk_sys) disable iff (!rst_n)
    active_q.pll[csrc_pkg::CSRC_POL_BIT] |=> clk_ctl.pol_negative)
    else $error("polarity not negative with bit 7 high");

  AST_POL_POS: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !active_q.pll[csrc_pkg::CSRC_POL_BIT] |=> !clk_ctl.pol_negative)
    else $error("polarity not positive with bit 7 low");
endmodule
`default_nettype wire

// [csrc_host.sv]
// Purpose: Host model that programs the block
// Assumes: One byte per access, strobes driven at the falling edge
// Notes: Data lines flip after each access so stale values are not trusted
`timescale 1ns/1ps
`default_nettype none
module csrc_host (
  input wire logic clk_sys,
  output logic reg_wr,
  output logic reg_rd,
  output logic [9:0] reg_addr,
  output logic [7:0] reg_wdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 10'h000;
    reg_wdata = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Settings first, update last
  task automatic acc(input logic wr, input logic [9:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_wr = wr;
    reg_rd = !wr;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = ~d;
  endtask
endmodule
`default_nettype wire

// [tb_clock_source_routing_config.sv]
// Purpose: Self-checking bench for the routing configuration block
// Assumes: Reads return staged values, update visible within three cycles
// Notes: Read results are checked by a monitor against a queue of notes
`timescale 1ns/1ps
`default_nettype none
module tb_clock_source_routing_config;
  logic clk_sys;
  logic rst_n;
  logic reg_wr;
  logic reg_rd;
  logic [9:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  csrc_pkg::csrc_cfg_t active_cfg;
  csrc_pkg::csrc_cfg_t exp_cfg;
  csrc_pkg::csrc_cfg_t stage;
  csrc_pkg::csrc_ctl_t clk_ctl;
  logic [7:0] rq[$];
  logic [31:0] r;
  int fails = 0;
  int num_checks = 0;
  csrc_host csrc_host_i(.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  csrc_top csrc_top_i(.clk_sys(clk_sys), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .active_cfg(active_cfg), .clk_ctl(clk_ctl));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic csrc_pkg::csrc_ctl_t ectl(csrc_pkg::csrc_cfg_t c);
    ectl.pll_on = c.pll[1:0] == csrc_pkg::CSRC_PWR_ON;
    ectl.osc_on = c.route[1];
    ectl.use_osc = c.route[1];
    ectl.bypass_div = c.route[0];
    ectl.pol_negative = c.pll[7];
    ectl.cal_start = c.cal[0];
    // Codes above four clamp, never below two
    ectl.div_ratio = (c.div[2:0] > 3'h4 ? 3'h4 : c.div[2:0]) + 3'h2;
  endfunction
  task automatic chk_cfg();
    num_checks++;
    if (active_cfg !== exp_cfg || clk_ctl !== ectl(exp_cfg)) begin
      fails++;
      $display("ERROR %0t active %h ctl %h", $time, active_cfg, clk_ctl);
    end
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    rq.push_back(e);
    csrc_host_i.acc(1'b0, a, 8'h00);
  endtask
  task automatic chk_rd();
    num_checks++;
    if (rq.size() == 0 || reg_rdata !== rq.pop_front()) begin
      fails++;
      $display("ERROR %0t read data %h", $time, reg_rdata);
    end
  endtask
  always @(negedge clk_sys) begin
    if (reg_rvalid === 1'b1) chk_rd();
  end
  task automatic print_verdict();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    void'($urandom(27));
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys) rst_n = 1'b1;
    exp_cfg = csrc_pkg::CSRC_CFG_RST;
    chk_cfg();
    rd(csrc_pkg::CSRC_ADDR_PLL, 8'h01);
    rd(csrc_pkg::CSRC_ADDR_DIV, 8'h02);
    rd(csrc_pkg::CSRC_ADDR_ROUTE, 8'h00);
    rd(10'h3ff, 8'h00);
    $display("test reset defaults done");
    for (int i = 0; i < 8; i++) begin
      r = $urandom;
      // Internal oscillator never bypasses the divider
      stage = {r[31:26], i[1:0], r[23:16], r[15:8], r[7:2], i[2], i[1] & ~i[2]};
      csrc_host_i.acc(1'b1, csrc_pkg::CSRC_ADDR_PLL, stage.pll);
      csrc_host_i.acc(1'b1, csrc_pkg::CSRC_ADDR_CAL, stage.cal);
      csrc_host_i.acc(1'b1, csrc_pkg::CSRC_ADDR_DIV, stage.div);
      csrc_host_i.acc(1'b1, csrc_pkg::CSRC_ADDR_ROUTE, stage.route);
      csrc_host_i.acc(1'b1, csrc_pkg::CSRC_ADDR_UPDATE, 8'hfe);
      repeat (3) @(negedge clk_sys);
      chk_cfg();
      csrc_host_i.acc(1'b1, csrc_pkg::CSRC_ADDR_UPDATE, 8'h01);
      rd(csrc_pkg::CSRC_ADDR_UPDATE, 8'h00);
      exp_cfg = stage;
      chk_cfg();
      rd(csrc_pkg::CSRC_ADDR_CAL, stage.cal);
    end
    $display("test staged update done");
    @(negedge clk_sys);
    rst_n = 1'b0;
    @(negedge clk_sys) rst_n = 1'b1;
    exp_cfg = csrc_pkg::CSRC_CFG_RST;
    chk_cfg();
    rd(csrc_pkg::CSRC_ADDR_ROUTE, 8'h00);
    for (int k = 0; k < 20 && rq.size() != 0; k++) @(negedge clk_sys);
    if (rq.size() != 0) begin
      fails++;
      $display("ERROR %0t read answers missing", $time);
    end
    $display("test mid-run reset done");
    print_verdict();
  end
endmodule
`default_nettype wire
